// file: common/phdc_pkg.sv
// Purpose: constants, types and helpers for the phase delay compensation block
// Assumes: 25 MHz core clock, 1.024 MHz processing tick, 16-bit register words
// Notes: register addresses are local to this block's parallel register port
package phdc_pkg;
	// ****************************************************************
	// register port
	// ****************************************************************
	localparam int unsigned ADDR_W          = 16;
	localparam int unsigned WORD_W          = 16;
	localparam int unsigned CAL_W           = 10;
	localparam logic [15:0] ADDR_PHASE_A    = 16'hE600;
	localparam logic [15:0] ADDR_PHASE_B    = 16'hE601;
	localparam logic [15:0] ADDR_PHASE_C    = 16'hE602;
	localparam logic [15:0] ADDR_CFG2       = 16'hE618;
	localparam logic [9:0]  CAL_RST         = 10'h000;
	localparam logic [7:0]  CFG2_RST        = 8'h00;
	localparam int unsigned EXTREF_BIT      = 0;
	localparam int unsigned CAL_DIR_BIT     = 9;
	localparam logic [9:0]  CAL_DLY_OFS     = 10'h200;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CORE_CLK_KHZ    = 25000;
	localparam int unsigned PROC_CLK_KHZ    = 1024;
	localparam int unsigned LSB_PS          = 976;
	localparam int unsigned ADV_MAX_PS      = 374000;
	localparam int unsigned DLY_MAX_PS      = 61500;
	localparam int unsigned ADV_MAX_LSB     = ADV_MAX_PS / LSB_PS;
	localparam int unsigned DLY_MAX_LSB     = DLY_MAX_PS / LSB_PS;
	localparam int unsigned ACC_W           = 15;
	localparam int unsigned TICK_GAP_MIN    = CORE_CLK_KHZ / PROC_CLK_KHZ;
	localparam int unsigned TICK_GAP_MAX    = (CORE_CLK_KHZ + PROC_CLK_KHZ - 1) / PROC_CLK_KHZ;

	// ****************************************************************
	// delay line
	// ****************************************************************
	localparam int unsigned TAP_W           = 9;
	localparam int unsigned LINE_DEPTH      = 512;
	localparam logic [8:0]  BASE_TAP        = 9'(ADV_MAX_LSB);

	typedef enum logic [1:0] {
		PM_FULL  = 2'b00,
		PM_ONE   = 2'b01,
		PM_TWO   = 2'b11,
		PM_SLEEP = 2'b10
	} phdc_pmode_e;

	// code is accepted when it is an advance up to the limit or a delay up to the limit
	function automatic logic phdc_cal_ok(input logic [9:0] code);
		logic ok;
		if (code[CAL_DIR_BIT]) begin
			ok = (code - CAL_DLY_OFS) <= 10'(DLY_MAX_LSB);
		end else begin
			ok = code <= 10'(ADV_MAX_LSB);
		end
		return ok;
	endfunction : phdc_cal_ok

	// voltage tap: base minus advance, or base plus delay
	function automatic logic [8:0] phdc_cal_tap(input logic [9:0] code);
		logic [9:0] t;
		if (code[CAL_DIR_BIT]) begin
			t = {1'b0, BASE_TAP} + (code - CAL_DLY_OFS);
		end else begin
			t = {1'b0, BASE_TAP} - code;
		end
		return t[8:0];
	endfunction : phdc_cal_tap
endpackage : phdc_pkg

// file: common/phdc_dl_if.sv
// Purpose: link between the compensation top and one sample delay line
// Assumes: all signals on core_clk
// Notes: tap counts processing ticks
`timescale 1ns/10ps
interface phdc_dl_if #(
	parameter int unsigned DATA_W = 24
);
	logic              tick;
	logic [DATA_W-1:0] din;
	logic [8:0]        tap;
	logic [DATA_W-1:0] dout;

	modport line (input tick, input din, input tap, output dout);
	modport user (output tick, output din, output tap, input dout);
endinterface : phdc_dl_if

// file: hdl/phdc_delay_line.sv
// Purpose: sample ring buffer with a programmable read tap
// Assumes: one sample written per processing tick
// Notes: tap 0 returns the incoming sample
`timescale 1ns/10ps
module phdc_delay_line
	import phdc_pkg::*;
#(
	parameter int unsigned DATA_W = 24,
	parameter int unsigned DEPTH  = LINE_DEPTH
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	phdc_dl_if.line   dl
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [DATA_W-1:0] mem [DEPTH];
	logic [AW-1:0]     wptr_q;
	logic [AW-1:0]     wptr_d;
	logic [DATA_W-1:0] dout_q;
	logic [DATA_W-1:0] dout_d;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		wptr_d = wptr_q;
		dout_d = dout_q;
		if (dl.tick) begin
			wptr_d = wptr_q + AW'(1);
			if (dl.tap == '0) begin
				dout_d = dl.din;
			end else begin
				dout_d = mem[wptr_q - AW'(dl.tap)];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wptr_q <= '0;
			dout_q <= '0;
		end else begin
			wptr_q <= wptr_d;
			dout_q <= dout_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (dl.tick) begin
			mem[wptr_q] <= dl.din;
		end
	end

	assign dl.dout = dout_q;
endmodule : phdc_delay_line

// file: hdl/phdc_top.sv
// Purpose: per-phase voltage path delay or advance against the current path
// Assumes: samples and register strobes come from logic on core_clk
// Notes: current path carries a fixed base delay so that advances are possible
`timescale 1ns/10ps
module phdc_top
	import phdc_pkg::*;
#(
	parameter int unsigned DATA_W = 24
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	input  wire logic                   reg_wr_en,
	input  wire logic                   reg_rd_en,
	input  wire logic [ADDR_W-1:0]      reg_addr,
	input  wire logic [WORD_W-1:0]      reg_wdata,
	output logic      [WORD_W-1:0]      reg_rdata,
	input  wire phdc_pmode_e            power_mode,
	input  wire logic [2:0][DATA_W-1:0] v_smp_in,
	input  wire logic [2:0][DATA_W-1:0] i_smp_in,
	output logic      [2:0][DATA_W-1:0] v_smp_out,
	output logic      [2:0][DATA_W-1:0] i_smp_out,
	output logic                        external_reference_select,
	output logic                        proc_tick
);
	logic [2:0][9:0]   cal_q;
	logic [2:0][9:0]   cal_d;
	logic [2:0][8:0]   vtap_q;
	logic [2:0][8:0]   vtap_d;
	logic [7:0]        cfg2_q;
	logic [7:0]        cfg2_d;
	logic [WORD_W-1:0] rdata_q;
	logic [WORD_W-1:0] rdata_d;
	logic [ACC_W-1:0]  acc_q;
	logic [ACC_W-1:0]  acc_d;
	logic              tick_q;
	logic              tick_d;
	logic [ACC_W:0]    acc_sum;
	logic [9:0]        wcode;

	// ****************************************************************
	// processing tick, fractional divide 25 MHz to 1.024 MHz
	// ****************************************************************
	always_comb begin
		acc_sum = {1'b0, acc_q} + (ACC_W+1)'(PROC_CLK_KHZ);
		if (acc_sum >= (ACC_W+1)'(CORE_CLK_KHZ)) begin
			acc_d  = ACC_W'(acc_sum - (ACC_W+1)'(CORE_CLK_KHZ));
			tick_d = 1'b1;
		end else begin
			acc_d  = acc_sum[ACC_W-1:0];
			tick_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			acc_q  <= acc_d;
			tick_q <= tick_d;
		end
	end

	// ****************************************************************
	// register port
	// ****************************************************************
	always_comb begin
		wcode   = reg_wdata[CAL_W-1:0];
		cal_d   = cal_q;
		cfg2_d  = cfg2_q;
		rdata_d = rdata_q;
		if (reg_wr_en && phdc_cal_ok(wcode)) begin
			unique case (reg_addr)
				ADDR_PHASE_A: cal_d[0] = wcode;
				ADDR_PHASE_B: cal_d[1] = wcode;
				ADDR_PHASE_C: cal_d[2] = wcode;
				default: ;
			endcase
		end
		if (reg_wr_en && reg_addr == ADDR_CFG2 && power_mode == PM_FULL) begin
			cfg2_d = reg_wdata[7:0];
		end
		if (reg_rd_en) begin
			unique case (reg_addr)
				ADDR_PHASE_A: rdata_d = {6'h00, cal_q[0]};
				ADDR_PHASE_B: rdata_d = {6'h00, cal_q[1]};
				ADDR_PHASE_C: rdata_d = {6'h00, cal_q[2]};
				ADDR_CFG2:    rdata_d = {8'h00, cfg2_q};
				default:      rdata_d = 16'h0000;
			endcase
		end
		for (int i = 0; i < 3; i++) begin
			vtap_d[i] = phdc_cal_tap(cal_q[i]);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_q   <= {3{CAL_RST}};
			cfg2_q  <= CFG2_RST;
			rdata_q <= '0;
			vtap_q  <= {3{BASE_TAP}};
		end else begin
			cal_q   <= cal_d;
			cfg2_q  <= cfg2_d;
			rdata_q <= rdata_d;
			vtap_q  <= vtap_d;
		end
	end

	assign reg_rdata                 = rdata_q;
	assign external_reference_select = cfg2_q[EXTREF_BIT];
	assign proc_tick                 = tick_q;

	// ****************************************************************
	// sample delay lines
	// ****************************************************************
	for (genvar g = 0; g < 3; g++) begin : g_phase
		phdc_dl_if #(.DATA_W(DATA_W)) v_if ();
		phdc_dl_if #(.DATA_W(DATA_W)) i_if ();
		assign v_if.tick = tick_q;
		assign v_if.din  = v_smp_in[g];
		assign v_if.tap  = vtap_q[g];
		assign i_if.tick = tick_q;
		assign i_if.din  = i_smp_in[g];
		assign i_if.tap  = BASE_TAP;
		phdc_delay_line #(.DATA_W(DATA_W)) u_v (
			.core_clk (core_clk),
			.rst_b    (rst_b),
			.dl       (v_if.line)
		);
		phdc_delay_line #(.DATA_W(DATA_W)) u_i (
			.core_clk (core_clk),
			.rst_b    (rst_b),
			.dl       (i_if.line)
		);
		assign v_smp_out[g] = v_if.dout;
		assign i_smp_out[g] = i_if.dout;
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	logic [5:0] gap_q;
	logic       seen_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_q  <= '0;
			seen_q <= 1'b0;
		end else begin
			gap_q  <= tick_q ? 6'h00 : gap_q + 6'h01;
			seen_q <= seen_q | tick_q;
		end
	end

	sequence s_wr_a;
		reg_wr_en && reg_addr == ADDR_PHASE_A && phdc_cal_ok(reg_wdata[9:0]);
	endsequence
	sequence s_cfg_wr_full;
		reg_wr_en && reg_addr == ADDR_CFG2 && power_mode == PM_FULL;
	endsequence

	property p_cal_write;
		@(posedge core_clk) disable iff (!rst_b)
		s_wr_a |=> cal_q[0] == $past(reg_wdata[9:0]);
	endproperty
	a_cal_write: assert property (p_cal_write) else $error("phase a cal not stored");

	property p_tap_span;
		@(posedge core_clk) disable iff (!rst_b)
		s_wr_a |=> ##1 (vtap_q[0] >= 9'h000 && vtap_q[0] <= 9'(ADV_MAX_LSB + DLY_MAX_LSB));
	endproperty
	a_tap_span: assert property (p_tap_span) else $error("tap outside shift span");

	property p_direction;
		@(posedge core_clk) disable iff (!rst_b)
		##1 (cal_q[1][CAL_DIR_BIT] && cal_q[1] != CAL_DLY_OFS) |=> vtap_q[1] > BASE_TAP;
	endproperty
	a_direction: assert property (p_direction) else $error("positive code did not delay");

	property p_tick_gap;
		@(posedge core_clk) disable iff (!rst_b)
		(tick_q && seen_q) |-> (gap_q + 6'h01 >= 6'(TICK_GAP_MIN) && gap_q + 6'h01 <= 6'(TICK_GAP_MAX));
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");

	property p_reject;
		@(posedge core_clk) disable iff (!rst_b)
		(reg_wr_en && reg_addr == ADDR_PHASE_B && !phdc_cal_ok(reg_wdata[9:0])
			&& !(reg_wr_en && reg_addr == ADDR_PHASE_B && phdc_cal_ok(reg_wdata[9:0])))
		|=> $stable(cal_q[1]);
	endproperty
	a_reject: assert property (p_reject) else $error("out of range code stored");

	property p_read_pad;
		@(posedge core_clk) disable iff (!rst_b)
		(reg_rd_en && reg_addr == ADDR_PHASE_C) |=> reg_rdata == {6'h00, $past(cal_q[2])};
	endproperty
	a_read_pad: assert property (p_read_pad) else $error("cal read word wrong");

	property p_ext_ref;
		@(posedge core_clk) disable iff (!rst_b)
		s_cfg_wr_full |=> external_reference_select == $past(reg_wdata[0]);
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("reference select not updated");

	property p_cfg_hold;
		@(posedge core_clk) disable iff (!rst_b)
		(power_mode != PM_FULL) |=> $stable(cfg2_q);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed outside full power");

	property p_zero_shift;
		@(posedge core_clk) disable iff (!rst_b)
		(cal_q[0] == CAL_RST)[*2] |-> vtap_q[0] == BASE_TAP;
	endproperty
	a_zero_shift: assert property (p_zero_shift) else $error("zero code shifted voltage");
endmodule : phdc_top

// file: verification/phdc_host_model.sv
// Purpose: host model driving the register port and power mode of the block
// Assumes: requests launched by non-blocking assignment at a rising edge
// Notes: released address and data lines carry the inverse of the last value
`timescale 1ns/10ps
module phdc_host_model
	import phdc_pkg::*;
(
	input  wire logic              core_clk,
	output logic                   reg_wr_en,
	output logic                   reg_rd_en,
	output logic      [ADDR_W-1:0] reg_addr,
	output logic      [WORD_W-1:0] reg_wdata,
	output phdc_pmode_e            power_mode
);
	// ****************************************************************
	// register access
	// ****************************************************************
	initial begin
		reg_wr_en  = 1'b0;
		reg_rd_en  = 1'b0;
		reg_addr   = 16'h0000;
		reg_wdata  = 16'h0000;
		power_mode = PM_FULL;
	end

	// encode a signed calibration result; upper six bits stay zero
	function automatic logic [15:0] cal_word(input int res);
		return (res <= 0) ? 16'(-res) : 16'(res + 512);
	endfunction : cal_word

	task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data);
		@(posedge core_clk);
		reg_wr_en <= wr;
		reg_rd_en <= !wr;
		reg_addr  <= addr;
		reg_wdata <= data;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		reg_rd_en <= 1'b0;
		reg_addr  <= ~addr;
		reg_wdata <= ~data;
	endtask : access

	task automatic set_mode(input phdc_pmode_e m);
		@(posedge core_clk);
		power_mode <= m;
	endtask : set_mode

	// config writes only in full power, mode settled one edge first
	task automatic cfg_write(input logic [15:0] data);
		@(posedge core_clk);
		if (power_mode == PM_FULL) begin
			access(1'b1, ADDR_CFG2, data);
		end
	endtask : cfg_write
endmodule : phdc_host_model

// file: verification/phase_delay_compensation_test.sv
// Purpose: self-checking bench for the phase delay compensation block
// Assumes: tick-count samples on all phases, so voltage minus current is the shift
// Notes: register reads are noted in a queue and checked by a monitor
`timescale 1ns/10ps
module phase_delay_compensation_test;
	import phdc_pkg::*;
	localparam int unsigned DW = 24;
	logic                   core_clk;
	logic                   rst_b;
	logic                   reg_wr_en;
	logic                   reg_rd_en;
	logic      [15:0]       reg_addr;
	logic      [15:0]       reg_wdata;
	logic      [15:0]       reg_rdata;
	phdc_pmode_e            power_mode;
	logic      [DW-1:0]     cnt = '0;
	wire logic [2:0][DW-1:0] smp_in = {3{cnt}};
	logic      [2:0][DW-1:0] v_out;
	logic      [2:0][DW-1:0] i_out;
	logic                   ext_ref;
	logic                   proc_tick;
	logic                   rd_d = 1'b0;
	logic      [15:0]       exp_q[$];
	logic      [15:0]       cal_addr[3] = '{ADDR_PHASE_A, ADDR_PHASE_B, ADDR_PHASE_C};
	phdc_pmode_e            modes[3] = '{PM_ONE, PM_TWO, PM_SLEEP};
	int                     res[3];
	int                     err_total = 0;
	int                     compares = 0;
	int                     seed = 17762;
	int                     gap = 0;
	int                     r;

	phdc_host_model host (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .power_mode(power_mode));

	phdc_top #(.DATA_W(DW)) dut (.core_clk(core_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .power_mode(power_mode), .v_smp_in(smp_in), .i_smp_in(smp_in),
		.v_smp_out(v_out), .i_smp_out(i_out), .external_reference_select(ext_ref),
		.proc_tick(proc_tick));

	// ****************************************************************
	// checking
	// ****************************************************************
	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("counts: compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
		exp_q.push_back(exp);
		host.access(1'b0, addr, 16'h0000);
	endtask : rd

	task automatic chk_shift();
		@(posedge core_clk iff proc_tick);
		@(posedge core_clk);
		#1;
		for (int g = 0; g < 3; g++) begin
			check(v_out[g] - i_out[g], DW'(-res[g]));
		end
	endtask : chk_shift

	always @(posedge core_clk) begin
		if (rd_d) begin
			check(DW'(reg_rdata), DW'(exp_q.pop_front()));
		end
		rd_d <= reg_rd_en;
		if (proc_tick) begin
			cnt <= cnt + 1'b1;
			if (gap != 0) begin
				check(DW'(gap == 24 || gap == 25), 24'h000001);
			end
			gap <= 1;
		end else if (gap != 0) begin
			gap <= gap + 1;
		end
	end

	// ****************************************************************
	// stimulus
	// ****************************************************************
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		#(40000 * 40);
		err_total++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		conclude();
	end

	initial begin
		rst_b = 1'b0;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int g = 0; g < 3; g++) rd(cal_addr[g], 16'h0000);
		rd(ADDR_CFG2, 16'h0000);
		rd(16'hE603, 16'h0000);
		check(DW'(ext_ref), 24'h000000);
		$display("test reset_values done");
		for (int k = 0; k < 2; k++) begin
			r = $unsigned($random(seed)) % 384;
			res[0] = k ? -383 : -r;
			r = $unsigned($random(seed)) % 64;
			res[1] = k ? 63 : r;
			res[2] = 0;
			for (int g = 0; g < 3; g++) begin
				host.access(1'b1, cal_addr[g], host.cal_word(res[g]));
				rd(cal_addr[g], host.cal_word(res[g]));
			end
			repeat (k ? 5 : 460) @(posedge core_clk iff proc_tick);
			chk_shift();
			$display("test shift round %0d done", k);
		end
		host.access(1'b1, ADDR_PHASE_A, 16'h0180);
		host.access(1'b1, ADDR_PHASE_B, 16'h0240);
		host.access(1'b1, ADDR_PHASE_C, 16'hFC05);
		rd(ADDR_PHASE_A, 16'h017F);
		rd(ADDR_PHASE_B, 16'h023F);
		rd(ADDR_PHASE_C, 16'h0005);
		$display("test refused_codes done");
		host.cfg_write(16'h0001);
		rd(ADDR_CFG2, 16'h0001);
		check(DW'(ext_ref), 24'h000001);
		for (int m = 0; m < 3; m++) begin
			host.set_mode(modes[m]);
			host.access(1'b1, ADDR_CFG2, 16'h0000);
			rd(ADDR_CFG2, 16'h0001);
			check(DW'(ext_ref), 24'h000001);
		end
		host.set_mode(PM_FULL);
		host.cfg_write(16'h0000);
		rd(ADDR_CFG2, 16'h0000);
		check(DW'(ext_ref), 24'h000000);
		repeat (2) @(posedge core_clk);
		$display("test config_retention done");
		conclude();
	end
endmodule : phase_delay_compensation_test
